// ### design/umci_top.sv
// Our own choices: the plain strobed port and the register addresses.
`include "umci_defs.svh"

module umci_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Modem pins
    input wire umci_pkg::umci_modem_t modem_n,
    output logic dtr_n,
    output logic rts_n,
    output logic op_n,
    output logic irq,
    output logic irq_oe_n,
    // Serial path
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic tx_core,
    output logic rx_core,
    // Neighbouring logic
    input wire logic enh_wr_en,
    input wire logic fifo_en,
    input wire logic auto_rts_en,
    input wire logic flow_rts_n,
    input wire logic rx_line_err,
    input wire logic rx_timeout,
    input wire logic rx_data_rdy,
    input wire logic thr_event,
    input wire logic tx_fifo_wr,
    input wire logic xoff_event,
    input wire logic rts_rise,
    input wire logic cts_rise,
    // Mode outputs
    output logic baud_en,
    output logic fifo_rdy_en,
    output logic xon_any_en,
    output logic tcr_tlr_open,
    output logic sleep_en
);

    umci_pkg::umci_state_t s;
    umci_pkg::umci_state_t n;
    logic loop;
    logic any_pend;
    logic [5:0] id_code;
    logic [3:0] live;
    logic wr_mcr;
    logic wr_ier;
    logic rd_msr;
    logic rd_iir;

    assign loop = s.modem_control_reg[`UMCI_MCR_LOOP];
    assign wr_mcr = wr_stb && addr == `UMCI_A_MCR;
    assign wr_ier = wr_stb && addr == `UMCI_A_IER;
    assign rd_msr = rd_stb && addr == `UMCI_A_MSR;
    assign rd_iir = rd_stb && addr == `UMCI_A_IIR;

    always_comb begin
        n = s;
        n.rd_data = 8'h00;
        // Priority encoder, first match wins
        any_pend = 1'b1;
        if (s.interrupt_enable_reg[`UMCI_IER_LSR] && rx_line_err) begin
            id_code = `UMCI_ID_LSR;
        end else if (s.interrupt_enable_reg[`UMCI_IER_RX] && rx_timeout) begin
            id_code = `UMCI_ID_TMO;
        end else if (s.interrupt_enable_reg[`UMCI_IER_RX] && rx_data_rdy) begin
            id_code = `UMCI_ID_RX;
        end else if (s.interrupt_enable_reg[`UMCI_IER_THR] && s.thr_pend) begin
            id_code = `UMCI_ID_THR;
        end else if (s.interrupt_enable_reg[`UMCI_IER_MSR] && s.dmsr != 4'h0) begin
            id_code = `UMCI_ID_MSR;
        end else if (s.interrupt_enable_reg[`UMCI_IER_XOFF] && s.xoff_pend) begin
            id_code = `UMCI_ID_XOFF;
        end else if (s.flow_pend) begin
            id_code = `UMCI_ID_FLOW;
        end else begin
            id_code = `UMCI_ID_NONE;
            any_pend = 1'b0;
        end

        // Pin synchronisers, a change counts once stages two and three agree
        n.ms1 = modem_n;
        n.ms2 = s.ms1;
        n.ms3 = s.ms2;
        for (int i = 0; i < 4; i++) begin
            if (s.ms2[i] == s.ms3[i]) begin
                n.mfilt[i] = s.ms3[i];
            end
        end
        n.rxs = {s.rxs[1:0], rx_pin};
        if (s.rxs[1] == s.rxs[2]) begin
            n.rx_filt = s.rxs[2];
        end

        // Modem line sources, loopback takes control outputs
        if (loop) begin
            live = {s.modem_control_reg[`UMCI_MCR_OUT], s.modem_control_reg[`UMCI_MCR_RDY], s.modem_control_reg[`UMCI_MCR_DTR], s.modem_control_reg[`UMCI_MCR_RTS]};
        end else begin
            live = ~s.mfilt;
        end
        n.line = live;

        // Delta bits: read clears, a new change in the same cycle wins
        if (rd_msr) begin
            n.dmsr = 4'h0;
        end
        n.dmsr[0] = n.dmsr[0] | (live[0] ^ s.line[0]);
        n.dmsr[1] = n.dmsr[1] | (live[1] ^ s.line[1]);
        n.dmsr[2] = n.dmsr[2] | (live[2] & ~s.line[2]);
        n.dmsr[3] = n.dmsr[3] | (live[3] ^ s.line[3]);

        // Event flags; re-enabling the holding interrupt never sets one
        if ((rd_iir && id_code == `UMCI_ID_THR) || tx_fifo_wr) begin
            n.thr_pend = 1'b0;
        end
        if (thr_event) begin
            n.thr_pend = 1'b1;
        end
        if (rd_iir && id_code == `UMCI_ID_XOFF) begin
            n.xoff_pend = 1'b0;
        end
        if (xoff_event) begin
            n.xoff_pend = 1'b1;
        end
        if (rd_iir && id_code == `UMCI_ID_FLOW) begin
            n.flow_pend = 1'b0;
        end
        if ((s.interrupt_enable_reg[`UMCI_IER_RTS] && rts_rise) || (s.interrupt_enable_reg[`UMCI_IER_CTS] && cts_rise)) begin
            n.flow_pend = 1'b1;
        end

        // Register writes
        if (wr_mcr) begin
            n.modem_control_reg[4:0] = wr_data[4:0];
            if (enh_wr_en) begin
                n.modem_control_reg[7:5] = wr_data[7:5];
            end
        end
        if (wr_ier) begin
            n.interrupt_enable_reg[3:0] = wr_data[3:0];
            if (enh_wr_en) begin
                n.interrupt_enable_reg[7:4] = wr_data[7:4];
            end
        end

        // Register reads, data one cycle later
        if (rd_stb) begin
            unique case (addr)
                `UMCI_A_MCR: n.rd_data = s.modem_control_reg;
                `UMCI_A_MSR: n.rd_data = {s.line, s.dmsr};
                `UMCI_A_IER: n.rd_data = s.interrupt_enable_reg;
                `UMCI_A_IIR: n.rd_data = {fifo_en, fifo_en, id_code};
                default: n.rd_data = 8'h00;
            endcase
        end

        // Prescaler enable
        n.pre_cnt = s.pre_cnt + 2'h1;
        n.baud_en = !s.modem_control_reg[`UMCI_MCR_PRE] || s.pre_cnt == `UMCI_PRE_LAST;

        // Pin outputs; in loopback dtr_n, rts_n and op_n sit inactive, while irq and irq_oe_n still follow control bit 3
        n.dtr_n = loop || !s.modem_control_reg[`UMCI_MCR_DTR];
        if (loop) begin
            n.rts_n = 1'b1;
        end else if (auto_rts_en) begin
            n.rts_n = flow_rts_n;
        end else begin
            n.rts_n = !s.modem_control_reg[`UMCI_MCR_RTS];
        end
        n.op_n = loop || !s.modem_control_reg[`UMCI_MCR_OUT];
        n.irq_oe_n = !s.modem_control_reg[`UMCI_MCR_OUT];
        n.irq = s.modem_control_reg[`UMCI_MCR_OUT] && any_pend;
        n.tx_pin = loop || tx_core;
        n.rx_core = loop ? tx_core : s.rx_filt;

        n.fifo_rdy_en = s.modem_control_reg[`UMCI_MCR_RDY];
        n.xon_any_en = s.modem_control_reg[`UMCI_MCR_XANY];
        n.tcr_tlr_open = s.modem_control_reg[`UMCI_MCR_TCR];
        n.sleep_en = s.interrupt_enable_reg[`UMCI_IER_SLEEP];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.modem_control_reg <= `UMCI_MCR_RST;
            s.interrupt_enable_reg <= `UMCI_IER_RST;
            s.ms1 <= `UMCI_PIN_IDLE;
            s.ms2 <= `UMCI_PIN_IDLE;
            s.ms3 <= `UMCI_PIN_IDLE;
            s.mfilt <= `UMCI_PIN_IDLE;
            s.rxs <= 3'h7;
            s.rx_filt <= 1'b1;
            s.dtr_n <= 1'b1;
            s.rts_n <= 1'b1;
            s.op_n <= 1'b1;
            s.irq_oe_n <= 1'b1;
            s.tx_pin <= 1'b1;
            s.rx_core <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign rd_data = s.rd_data;
    assign dtr_n = s.dtr_n;
    assign rts_n = s.rts_n;
    assign op_n = s.op_n;
    assign irq = s.irq;
    assign irq_oe_n = s.irq_oe_n;
    assign tx_pin = s.tx_pin;
    assign rx_core = s.rx_core;
    assign baud_en = s.baud_en;
    assign fifo_rdy_en = s.fifo_rdy_en;
    assign xon_any_en = s.xon_any_en;
    assign tcr_tlr_open = s.tcr_tlr_open;
    assign sleep_en = s.sleep_en;

    sequence s_mcr_out_wr;
        wr_mcr && wr_data[`UMCI_MCR_OUT] && !wr_data[`UMCI_MCR_LOOP];
    endsequence

    a_dtr_follow: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(loop) |-> dtr_n == !$past(s.modem_control_reg[`UMCI_MCR_DTR]))
        else $error("terminal-ready pin does not follow control bit 0");

    a_rts_manual: assert property (@(posedge clk) disable iff (sys_rst)
        wr_mcr && !wr_data[`UMCI_MCR_LOOP] ##1 !auto_rts_en |=> rts_n == !$past(wr_data[`UMCI_MCR_RTS], 2))
        else $error("RTS pin does not follow control bit 1");

    a_out_drive: assert property (@(posedge clk) disable iff (sys_rst)
        s_mcr_out_wr ##1 !wr_mcr |=> !op_n && !irq_oe_n)
        else $error("general output or interrupt enable wrong after control bit 3 set");

    a_loop_status: assert property (@(posedge clk) disable iff (sys_rst)
        rd_msr && loop && $stable(s.modem_control_reg) |=> rd_data[7:4] == {$past(s.modem_control_reg[3]), $past(s.modem_control_reg[2]),
            $past(s.modem_control_reg[0]), $past(s.modem_control_reg[1])})
        else $error("loopback status does not mirror control bits");

    a_mcr_guard: assert property (@(posedge clk) disable iff (sys_rst)
        wr_mcr && !enh_wr_en |=> s.modem_control_reg[7:5] == $past(s.modem_control_reg[7:5]))
        else $error("protected control bits changed without write enable");

    a_ier_guard: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ier && !enh_wr_en |=> s.interrupt_enable_reg[7:4] == $past(s.interrupt_enable_reg[7:4]))
        else $error("protected enable bits changed without write enable");

    a_delta_clear: assert property (@(posedge clk) disable iff (sys_rst)
        rd_msr ##1 $stable(s.line) |-> s.dmsr == 4'h0)
        else $error("status delta bits not cleared by read");

    a_ring_edge: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s.line[2]) |-> s.dmsr[2])
        else $error("ring rising edge not latched");

    a_ident_idle: assert property (@(posedge clk) disable iff (sys_rst)
        rd_iir && !any_pend |=> rd_data == {{2{$past(fifo_en)}}, `UMCI_ID_NONE})
        else $error("identification wrong with nothing pending");

    a_irq_hold: assert property (@(posedge clk) disable iff (sys_rst)
        any_pend && s.modem_control_reg[`UMCI_MCR_OUT] |=> irq)
        else $error("interrupt not asserted while source pending");

    a_thr_reenable: assert property (@(posedge clk) disable iff (sys_rst)
        !s.thr_pend && wr_ier && !thr_event |=> !s.thr_pend)
        else $error("enable write raised a holding interrupt");

endmodule

// ### design/umci_defs.svh
`ifndef UMCI_DEFS_SVH
`define UMCI_DEFS_SVH

// Register offsets on the byte port
`define UMCI_A_MCR 3'h0
`define UMCI_A_MSR 3'h1
`define UMCI_A_IER 3'h2
`define UMCI_A_IIR 3'h3

// Modem control fields
`define UMCI_MCR_DTR 0
`define UMCI_MCR_RTS 1
`define UMCI_MCR_RDY 2
`define UMCI_MCR_OUT 3
`define UMCI_MCR_LOOP 4
`define UMCI_MCR_XANY 5
`define UMCI_MCR_TCR 6
`define UMCI_MCR_PRE 7

// Interrupt enable fields
`define UMCI_IER_RX 0
`define UMCI_IER_THR 1
`define UMCI_IER_LSR 2
`define UMCI_IER_MSR 3
`define UMCI_IER_SLEEP 4
`define UMCI_IER_XOFF 5
`define UMCI_IER_RTS 6
`define UMCI_IER_CTS 7

// Identification codes, bits 5..0
`define UMCI_ID_NONE 6'h01
`define UMCI_ID_LSR 6'h06
`define UMCI_ID_TMO 6'h0C
`define UMCI_ID_RX 6'h04
`define UMCI_ID_THR 6'h02
`define UMCI_ID_MSR 6'h00
`define UMCI_ID_XOFF 6'h10
`define UMCI_ID_FLOW 6'h20

// Reset values and the prescaler's last count
`define UMCI_MCR_RST 8'h00
`define UMCI_IER_RST 8'h00
`define UMCI_PIN_IDLE 4'hF
`define UMCI_PRE_LAST 2'h3

`endif

// ### design/umci_pkg.sv
package umci_pkg;

    // Active-low modem inputs, bit order as in the status register
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } umci_modem_t;

    typedef struct packed {
        logic [7:0] modem_control_reg;
        logic [7:0] interrupt_enable_reg;
        logic [3:0] dmsr;
        logic [3:0] line;
        logic [3:0] ms1;
        logic [3:0] ms2;
        logic [3:0] ms3;
        logic [3:0] mfilt;
        logic [2:0] rxs;
        logic rx_filt;
        logic thr_pend;
        logic xoff_pend;
        logic flow_pend;
        logic [1:0] pre_cnt;
        logic [7:0] rd_data;
        logic dtr_n;
        logic rts_n;
        logic op_n;
        logic irq;
        logic irq_oe_n;
        logic tx_pin;
        logic rx_core;
        logic baud_en;
        logic fifo_rdy_en;
        logic xon_any_en;
        logic tcr_tlr_open;
        logic sleep_en;
    } umci_state_t;

endpackage

// ### sim/umci_modem_model.sv
module umci_modem_model #(
    parameter int DELAY = 3
) (
    // Clock
    input wire logic clk,
    // Handshake requests from the device
    input wire logic dtr_n,
    input wire logic rts_n,
    // Line commands from the bench
    input wire logic cd_n_cmd,
    input wire logic ri_n_cmd,
    // Lines toward the device
    output umci_pkg::umci_modem_t modem_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DELAY-1:0] dtr_dly = '1;
    logic [DELAY-1:0] rts_dly = '1;

    // Data set answers ready and clear-to-send after a turnaround
    always_ff @(posedge clk) begin
        dtr_dly <= {dtr_dly[DELAY-2:0], dtr_n};
        rts_dly <= {rts_dly[DELAY-2:0], rts_n};
    end

    // One driver for the whole struct: cd, ri, dsr, cts
    assign modem_n = {cd_n_cmd, ri_n_cmd, dtr_dly[DELAY-1], rts_dly[DELAY-1]};
endmodule

// ### sim/uart_modem_ctrl_and_interrupts_test.sv
module uart_modem_ctrl_and_interrupts_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, sys_rst, wr_stb, rd_stb, rx_pin, tx_core, enh_wr_en, fifo_en, auto_rts_en, flow_rts_n;
    logic rx_line_err, rx_timeout, rx_data_rdy, thr_event, tx_fifo_wr, xoff_event, rts_rise, cts_rise;
    logic cd_n_cmd, ri_n_cmd, dtr_n, rts_n, op_n, irq, irq_oe_n, tx_pin, rx_core;
    logic baud_en, fifo_rdy_en, xon_any_en, tcr_tlr_open, sleep_en;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data;
    umci_pkg::umci_modem_t modem_n;
    int err_total = 0;
    int tests_run = 0;

    umci_top dut (.clk, .sys_rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .modem_n, .dtr_n, .rts_n,
        .op_n, .irq, .irq_oe_n, .rx_pin, .tx_pin, .tx_core, .rx_core, .enh_wr_en, .fifo_en, .auto_rts_en,
        .flow_rts_n, .rx_line_err, .rx_timeout, .rx_data_rdy, .thr_event, .tx_fifo_wr, .xoff_event,
        .rts_rise, .cts_rise, .baud_en, .fifo_rdy_en, .xon_any_en, .tcr_tlr_open, .sleep_en);

    umci_modem_model #(.DELAY(3)) modem (.clk, .dtr_n, .rts_n, .cd_n_cmd, .ri_n_cmd, .modem_n);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        err_total++;
        $display("CHECK FAILED %0t %s", $time, msg);
    endtask

    task automatic chk_pin(input logic got, input logic exp, input string msg);
        tests_run++;
        if (got !== exp) fail(msg);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'h1;
        @(posedge clk);
        wr_stb <= 1'h0;
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge clk);
        rd_stb <= 1'h0;
        #1;
        tests_run++;
        if ((rd_data & mask) !== (exp & mask)) fail($sformatf("read %0h got %0h", a, rd_data));
    endtask

    task automatic wait_irq(input logic v);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (irq === v) return;
        end
        fail("interrupt wait ran out");
        end_sim();
    endtask

    task automatic cnt_baud(input int exp);
        int n;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (baud_en === 1'h1) n++;
        end
        tests_run++;
        if (n != exp) fail("baud enable rate");
    endtask

    initial begin
        {wr_stb, rd_stb, tx_core, enh_wr_en, fifo_en, auto_rts_en, tx_fifo_wr} = '0;
        {rx_line_err, rx_timeout, rx_data_rdy, thr_event, xoff_event, rts_rise, cts_rise} = '0;
        {rx_pin, flow_rts_n, cd_n_cmd, ri_n_cmd, sys_rst} = '1;
        addr = 3'h0;
        wr_data = 8'h00;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        chk_pin(dtr_n, 1'h1, "dtr after reset");
        chk_pin(irq_oe_n, 1'h1, "irq enable after reset");
        rd_reg(3'h0, 8'h00, 8'hFF);
        rd_reg(3'h2, 8'h00, 8'hFF);
        rd_reg(3'h3, 8'h01, 8'hFF);
        chk_pin(tx_pin, 1'h0, "tx follows core");
        rx_pin <= 1'h0;
        cyc(6);
        chk_pin(rx_core, 1'h0, "rx follows pin");
        rx_pin <= 1'h1;
        wr_reg(3'h0, 8'hEF);
        rd_reg(3'h0, 8'h0F, 8'hFF);
        chk_pin(dtr_n, 1'h0, "dtr active");
        chk_pin(rts_n, 1'h0, "rts active");
        chk_pin(op_n, 1'h0, "output pin low");
        chk_pin(irq_oe_n, 1'h0, "irq driven");
        chk_pin(fifo_rdy_en, 1'h1, "fifo ready enable");
        wr_reg(3'h2, 8'hF8);
        rd_reg(3'h2, 8'h08, 8'hFF);
        enh_wr_en <= 1'h1;
        wr_reg(3'h2, 8'hF8);
        wr_reg(3'h0, 8'hEF);
        rd_reg(3'h2, 8'hF8, 8'hFF);
        cyc(1);
        chk_pin(sleep_en, 1'h1, "sleep enable");
        chk_pin(xon_any_en, 1'h1, "resume on any");
        chk_pin(tcr_tlr_open, 1'h1, "threshold access");
        cnt_baud(2);
        wr_reg(3'h0, 8'h0F);
        cyc(2);
        cnt_baud(8);
        wait_irq(1'h1);
        rd_reg(3'h3, 8'h00, 8'hFF);
        rd_reg(3'h1, 8'h33, 8'hFF);
        rd_reg(3'h1, 8'h30, 8'hFF);
        wait_irq(1'h0);
        ri_n_cmd <= 1'h0;
        wait_irq(1'h1);
        rd_reg(3'h1, 8'h74, 8'hFF);
        ri_n_cmd <= 1'h1;
        cyc(8);
        rd_reg(3'h1, 8'h30, 8'hFF);
        cd_n_cmd <= 1'h0;
        wait_irq(1'h1);
        rd_reg(3'h1, 8'hB8, 8'hFF);
        cd_n_cmd <= 1'h1;
        fifo_en <= 1'h1;
        wr_reg(3'h2, 8'hFF);
        {rx_line_err, rx_timeout, rx_data_rdy, thr_event, xoff_event, rts_rise, cts_rise} <= '1;
        @(posedge clk);
        {thr_event, xoff_event, rts_rise, cts_rise} <= '0;
        cyc(8);
        rd_reg(3'h3, 8'hC6, 8'hFF);
        rx_line_err <= 1'h0;
        cyc(2);
        rd_reg(3'h3, 8'hCC, 8'hFF);
        rx_timeout <= 1'h0;
        cyc(2);
        rd_reg(3'h3, 8'hC4, 8'hFF);
        rx_data_rdy <= 1'h0;
        cyc(2);
        rd_reg(3'h3, 8'hC2, 8'hFF);
        rd_reg(3'h3, 8'hC0, 8'hFF);
        rd_reg(3'h1, 8'h08, 8'h0F);
        rd_reg(3'h3, 8'hD0, 8'hFF);
        rd_reg(3'h3, 8'hE0, 8'hFF);
        rd_reg(3'h3, 8'hC1, 8'hFF);
        wait_irq(1'h0);
        wr_reg(3'h2, 8'hFD);
        wr_reg(3'h2, 8'hFF);
        cyc(2);
        rd_reg(3'h3, 8'hC1, 8'hFF);
        wr_reg(3'h2, 8'hF0);
        rx_line_err <= 1'h1;
        cyc(3);
        rd_reg(3'h3, 8'hC1, 8'hFF);
        chk_pin(irq, 1'h0, "masked source");
        wr_reg(3'h2, 8'hF4);
        wait_irq(1'h1);
        rd_reg(3'h3, 8'hC6, 8'hFF);
        rx_line_err <= 1'h0;
        auto_rts_en <= 1'h1;
        cyc(3);
        chk_pin(rts_n, 1'h1, "auto rts");
        wr_reg(3'h0, 8'h07);
        cyc(2);
        chk_pin(op_n, 1'h1, "output pin high");
        chk_pin(irq_oe_n, 1'h1, "irq floated");
        wr_reg(3'h0, 8'h1B);
        cyc(4);
        chk_pin(dtr_n, 1'h1, "dtr in loopback");
        chk_pin(tx_pin, 1'h1, "tx held in loopback");
        chk_pin(rx_core, 1'h0, "loopback serial");
        rd_reg(3'h1, 8'hB0, 8'hF0);
        tx_core <= 1'h1;
        cyc(3);
        chk_pin(rx_core, 1'h1, "loopback serial high");
        rd_reg(3'h5, 8'h00, 8'hFF);
        end_sim();
    end
endmodule
